/* hw/dps_host.sv */
`timescale 1ns/100ps
// What this block does
// - host initializes semaphores after power-up itself.
// - init writes one into every semaphore location.
// - acquire by writing zero then reading back; zero means granted.
// - owner releases a token by writing one to it.
module dps_host #(
  parameter int ADDR_W = dps_pkg::ADDR_W,
  parameter int DATA_W = dps_pkg::DATA_W
) (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic                       cmd_valid,
  input  wire dps_pkg::dps_cmd_t          cmd_op,
  input  wire logic [dps_pkg::IDX_W-1:0]  cmd_index,
  output logic                            cmd_ready_q,
  output logic                            rsp_valid_q,
  output logic                            rsp_granted_q,
  output logic [dps_pkg::NUM_TOKENS-1:0]  owned_q,
  output logic                            init_done_q,
  output logic                            semaphore_select_n_q,
  output logic                            oe_n_q,
  output logic                            rw_n_q,
  output logic [ADDR_W-1:0]               addr_q,
  input  wire logic [DATA_W-1:0]          io_in,
  output logic [DATA_W-1:0]               io_out_q,
  output logic                            io_oe_q
);
  if (ADDR_W < dps_pkg::IDX_W) begin : g_bad_addr
    $error("dps_host: address width cannot hold a token index");
  end
  if (DATA_W < 1) begin : g_bad_data
    $error("dps_host: data width must be at least one");
  end
  if (dps_pkg::SETUP_CYC >= 2 ** dps_pkg::CNT_W ||
      dps_pkg::STROBE_CYC >= 2 ** dps_pkg::CNT_W) begin : g_bad_cnt
    $error("dps_host: pin timing counts overflow the cycle counter");
  end
  if (dps_pkg::NUM_TOKENS > 2 ** dps_pkg::IDX_W) begin : g_bad_idx
    $error("dps_host: token count exceeds the index width");
  end

  typedef enum logic [2:0] {
    DPS_ST_INIT  = 3'b000,
    DPS_ST_IDLE  = 3'b001,
    DPS_ST_WR    = 3'b010,
    DPS_ST_RD    = 3'b011,
    DPS_ST_WAIT  = 3'b100
  } dps_st_t;

  localparam logic [dps_pkg::IDX_W-1:0] LAST_IDX = dps_pkg::IDX_W'(dps_pkg::NUM_TOKENS - 1);

  function automatic logic [ADDR_W-1:0] tok_addr(input logic [dps_pkg::IDX_W-1:0] idx);
    tok_addr = {{(ADDR_W - dps_pkg::IDX_W){1'b0}}, idx};
  endfunction

  // a pin cycle of the given kind has just come back
  function automatic logic cycle_end(input dps_st_t st, input logic done,
                                     input dps_st_t ret, input dps_st_t kind);
    cycle_end = (st == DPS_ST_WAIT) && done && (ret == kind);
  endfunction

  // zero read back means this port holds the token
  function automatic logic is_grant(input logic rbit);
    is_grant = (rbit == dps_pkg::FLAG_TAKE);
  endfunction

  dps_st_t                     st_q;
  dps_st_t                     ret_q;
  dps_pkg::dps_cmd_t           op_q;
  logic [dps_pkg::IDX_W-1:0]   idx_q;
  logic                        pc_start_q;
  logic                        pc_wr_q;
  logic                        pc_bit_q;
  logic                        pc_done;
  logic                        pc_rbit;
  logic                        init_step_end;
  logic                        cmd_end;

  assign init_step_end = cycle_end(st_q, pc_done, ret_q, DPS_ST_INIT);
  assign cmd_end       = cycle_end(st_q, pc_done, ret_q, DPS_ST_IDLE);

  dps_pin_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
    .mclk      (mclk),
    .rst       (rst),
    .start     (pc_start_q),
    .is_write  (pc_wr_q),
    .addr      (tok_addr(idx_q)),
    .wdata_bit (pc_bit_q),
    .io_in     (io_in),
    .done_q    (pc_done),
    .rbit_q    (pc_rbit),
    .sem_n_q   (semaphore_select_n_q),
    .oe_n_q    (oe_n_q),
    .rw_n_q    (rw_n_q),
    .addr_q    (addr_q),
    .io_out_q  (io_out_q),
    .io_oe_q   (io_oe_q)
  );

  // sequencing of commands onto pin cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q        <= DPS_ST_INIT;
      ret_q       <= DPS_ST_INIT;
      op_q        <= dps_pkg::DPS_CMD_INIT;
      idx_q       <= '0;
      pc_start_q  <= 1'b0;
      pc_wr_q     <= 1'b0;
      pc_bit_q    <= dps_pkg::FLAG_FREE;
      cmd_ready_q <= 1'b0;
    end else begin
      pc_start_q <= 1'b0;
      case (st_q)
        DPS_ST_INIT: begin
          // free every token after reset
          pc_wr_q    <= 1'b1;
          pc_bit_q   <= dps_pkg::FLAG_FREE;
          pc_start_q <= 1'b1;
          ret_q      <= DPS_ST_INIT;
          st_q       <= DPS_ST_WAIT;
        end
        DPS_ST_IDLE: begin
          if (cmd_valid && cmd_ready_q) begin
            cmd_ready_q <= 1'b0;
            op_q        <= cmd_op;
            idx_q       <= cmd_index;
            case (cmd_op)
              dps_pkg::DPS_CMD_INIT: begin
                idx_q       <= '0;
                st_q        <= DPS_ST_INIT;
              end
              dps_pkg::DPS_CMD_POLL: st_q <= DPS_ST_RD;
              default: st_q <= DPS_ST_WR;
            endcase
          end else begin
            cmd_ready_q <= 1'b1;
          end
        end
        DPS_ST_WR: begin
          pc_wr_q    <= 1'b1;
          pc_bit_q   <= (op_q == dps_pkg::DPS_CMD_RELEASE) ?
                        dps_pkg::FLAG_FREE : dps_pkg::FLAG_TAKE;
          pc_start_q <= 1'b1;
          ret_q      <= (op_q == dps_pkg::DPS_CMD_ACQUIRE) ? DPS_ST_RD : DPS_ST_IDLE;
          st_q       <= DPS_ST_WAIT;
        end
        DPS_ST_RD: begin
          pc_wr_q    <= 1'b0;
          pc_start_q <= 1'b1;
          ret_q      <= DPS_ST_IDLE;
          st_q       <= DPS_ST_WAIT;
        end
        DPS_ST_WAIT: begin
          if (pc_done) begin
            if (ret_q == DPS_ST_INIT) begin
              if (idx_q == LAST_IDX) begin
                idx_q       <= '0;
                st_q        <= DPS_ST_IDLE;
              end else begin
                idx_q <= idx_q + 1'b1;
                st_q  <= DPS_ST_INIT;
              end
            end else begin
              st_q <= ret_q;
            end
          end
        end
        default: st_q <= DPS_ST_INIT;
      endcase
    end
  end

  // one-cycle answer strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= cmd_end;
    end
  end

  // grant flag holds until the next answer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_granted_q <= 1'b0;
    end else if (cmd_end) begin
      if (op_q == dps_pkg::DPS_CMD_RELEASE) begin
        rsp_granted_q <= 1'b0;
      end else begin
        rsp_granted_q <= is_grant(pc_rbit);
      end
    end
  end

  // local view of held tokens
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      owned_q <= '0;
    end else if (init_step_end) begin
      owned_q <= '0;
    end else if (cmd_end) begin
      if (op_q == dps_pkg::DPS_CMD_RELEASE) begin
        owned_q[idx_q] <= 1'b0;
      end else begin
        owned_q[idx_q] <= is_grant(pc_rbit);
      end
    end
  end

  // high once every token has been freed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      init_done_q <= 1'b0;
    end else if (st_q == DPS_ST_IDLE && cmd_valid && cmd_ready_q &&
                 cmd_op == dps_pkg::DPS_CMD_INIT) begin
      init_done_q <= 1'b0;
    end else if (init_step_end && idx_q == LAST_IDX) begin
      init_done_q <= 1'b1;
    end
  end
endmodule

/* hw/dps_pin_cycle.sv */
`timescale 1ns/100ps
// one semaphore-space access on the port pins, strobes released between cycles
module dps_pin_cycle #(
  parameter int ADDR_W = dps_pkg::ADDR_W,
  parameter int DATA_W = dps_pkg::DATA_W
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic              is_write,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              wdata_bit,
  input  wire logic [DATA_W-1:0] io_in,
  output logic                   done_q,
  output logic                   rbit_q,
  output logic                   sem_n_q,
  output logic                   oe_n_q,
  output logic                   rw_n_q,
  output logic [ADDR_W-1:0]      addr_q,
  output logic [DATA_W-1:0]      io_out_q,
  output logic                   io_oe_q
);
  typedef enum logic [1:0] {
    DPS_PC_IDLE  = 2'b00,
    DPS_PC_SETUP = 2'b01,
    DPS_PC_STRB  = 2'b10,
    DPS_PC_DONE  = 2'b11
  } dps_pc_t;

  localparam logic [dps_pkg::CNT_W-1:0] SETUP_N = dps_pkg::CNT_W'(dps_pkg::SETUP_CYC);
  localparam logic [dps_pkg::CNT_W-1:0] STRB_N  = dps_pkg::CNT_W'(dps_pkg::STROBE_CYC);

  dps_pc_t                   st_q;
  logic [dps_pkg::CNT_W-1:0] cnt_q;
  logic                      wr_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q     <= DPS_PC_IDLE;
      cnt_q    <= '0;
      wr_q     <= 1'b0;
      done_q   <= 1'b0;
      rbit_q   <= 1'b1;
      sem_n_q  <= 1'b1;
      oe_n_q   <= 1'b1;
      rw_n_q   <= 1'b1;
      addr_q   <= '0;
      io_out_q <= '1;
      io_oe_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        DPS_PC_IDLE: begin
          if (start) begin
            wr_q     <= is_write;
            addr_q   <= addr;
            io_out_q <= {DATA_W{wdata_bit}};
            io_oe_q  <= is_write;
            rw_n_q   <= ~is_write;
            sem_n_q  <= 1'b0;
            cnt_q    <= SETUP_N;
            st_q     <= DPS_PC_SETUP;
          end
        end
        DPS_PC_SETUP: begin
          if (cnt_q <= 1) begin
            oe_n_q <= wr_q;
            cnt_q  <= STRB_N;
            st_q   <= DPS_PC_STRB;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        DPS_PC_STRB: begin
          if (cnt_q <= 1) begin
            rbit_q  <= io_in[0];
            sem_n_q <= 1'b1;
            oe_n_q  <= 1'b1;
            rw_n_q  <= 1'b1;
            io_oe_q <= 1'b0;
            st_q    <= DPS_PC_DONE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        DPS_PC_DONE: begin
          done_q <= 1'b1;
          st_q   <= DPS_PC_IDLE;
        end
        default: st_q <= DPS_PC_IDLE;
      endcase
    end
  end
endmodule

/* inc/dps_pkg.sv */
package dps_pkg;
  localparam int NUM_TOKENS   = 8;
  localparam int IDX_W        = 3;
  localparam int DATA_W       = 16;
  localparam int ADDR_W       = 13;
  // pin timing in ns, converted to mclk cycles
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETUP_NS      = 20;
  localparam int STROBE_NS     = 25;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W      = 4;
  localparam logic FLAG_TAKE = 1'b0;
  localparam logic FLAG_FREE = 1'b1;
  typedef enum logic [1:0] {
    DPS_CMD_INIT    = 2'b00,
    DPS_CMD_ACQUIRE = 2'b01,
    DPS_CMD_RELEASE = 2'b10,
    DPS_CMD_POLL    = 2'b11
  } dps_cmd_t;
endpackage

/* tb/dps_dev_model.sv */
`timescale 1ns/100ps
module dps_dev_model (
  input  wire logic        mclk,
  input  wire logic        sem_n,
  input  wire logic        oe_n,
  input  wire logic        rw_n,
  input  wire logic [12:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wdata_oe,
  input  wire logic        r_wr,
  input  wire logic [2:0]  r_idx,
  input  wire logic        r_bit,
  output logic      [15:0] rdata
);
  logic [7:0]  lreq = 8'hff;
  logic [7:0]  rreq = 8'hff;
  logic [7:0]  lown = 8'h00;
  logic [7:0]  rown = 8'h00;
  logic        lat = 1'b1;
  logic        rd_act = 1'b0;
  logic [15:0] last = 16'h0000;
  wire  [2:0]  a = addr[2:0];
  // released bus toggles so stale data never looks valid
  assign rdata = rd_act ? {16{lat}} : ~last;
  always @(posedge mclk) begin
    last <= rdata;
    if (!sem_n && !rw_n && wdata_oe) lreq[a] <= !wdata[0];
    if (r_wr) rreq[r_idx] <= !r_bit;
    for (int i = 0; i < 8; i++) begin
      if (!lown[i] && !rown[i]) begin
        lown[i] <= lreq[i];
        rown[i] <= rreq[i] && !lreq[i];
      end else if (lown[i] && !lreq[i]) begin
        lown[i] <= 1'b0;
        rown[i] <= rreq[i];
      end else if (rown[i] && !rreq[i]) begin
        rown[i] <= 1'b0;
        lown[i] <= lreq[i];
      end
    end
    if (sem_n || oe_n) rd_act <= 1'b0;
    else if (!rd_act) begin
      rd_act <= 1'b1;
      lat <= !lown[a];
    end
  end
endmodule

/* tb/dps_host_bench.sv */
`timescale 1ns/100ps
module dps_host_bench;
  logic mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, r_wr = 1'b0, r_bit = 1'b1;
  dps_pkg::dps_cmd_t cmd_op = dps_pkg::DPS_CMD_POLL;
  logic [2:0] cmd_index = 3'h0, r_idx = 3'h0;
  logic cmd_ready_q, rsp_valid_q, rsp_granted_q, init_done_q, sem_n, oe_n, rw_n, io_oe;
  logic [7:0] owned_q, rh;
  logic [12:0] addr;
  logic [15:0] io_in, io_out;
  logic exp_q[$];
  int num_errors = 0, n_compared = 0;
  initial forever #2.5 mclk = ~mclk;
  dps_host DUT (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_index(cmd_index), .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q),
    .rsp_granted_q(rsp_granted_q), .owned_q(owned_q), .init_done_q(init_done_q),
    .semaphore_select_n_q(sem_n), .oe_n_q(oe_n), .rw_n_q(rw_n), .addr_q(addr),
    .io_in(io_in), .io_out_q(io_out), .io_oe_q(io_oe));
  dps_dev_model u_dev (.mclk(mclk), .sem_n(sem_n), .oe_n(oe_n), .rw_n(rw_n), .addr(addr),
    .wdata(io_out), .wdata_oe(io_oe), .r_wr(r_wr), .r_idx(r_idx), .r_bit(r_bit),
    .rdata(io_in));
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmd(dps_pkg::dps_cmd_t op, logic [2:0] idx, logic e);
    if (op != dps_pkg::DPS_CMD_INIT) exp_q.push_back(e);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_index <= idx;
    do @(posedge mclk); while (cmd_ready_q !== 1'b1);
    cmd_valid <= 1'b0;
    @(posedge mclk);
    while (cmd_ready_q !== 1'b1) @(posedge mclk);
  endtask
  // far side writes one flag through its own port
  task automatic rport(logic [2:0] i, logic b);
    @(posedge mclk);
    r_wr <= 1'b1;
    r_idx <= i;
    r_bit <= b;
    @(posedge mclk);
    r_wr <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  always @(posedge mclk) if (rsp_valid_q === 1'b1) begin
    if (exp_q.size() == 0) check("unexpected answer", 8'h01, 8'h00);
    else check("granted", {7'h0, rsp_granted_q}, {7'h0, exp_q.pop_front()});
  end
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h03e3));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rport(3'(i), 1'b1);
    while (init_done_q !== 1'b1) @(posedge mclk);
    rh = 8'($urandom);
    for (int i = 0; i < 8; i++) begin
      if (rh[i]) rport(3'(i), 1'b0);
      cmd(dps_pkg::DPS_CMD_ACQUIRE, 3'(i), !rh[i]);
    end
    check("owned", owned_q, ~rh);
    for (int i = 0; i < 8; i++) begin
      cmd(dps_pkg::DPS_CMD_RELEASE, 3'(i), 1'b0);
      if (rh[i]) rport(3'(i), 1'b1);
    end
    cmd(dps_pkg::DPS_CMD_ACQUIRE, 3'h3, 1'b1);
    rport(3'h3, 1'b0);
    cmd(dps_pkg::DPS_CMD_RELEASE, 3'h3, 1'b0);
    cmd(dps_pkg::DPS_CMD_POLL, 3'h3, 1'b0);
    rport(3'h3, 1'b1);
    cmd(dps_pkg::DPS_CMD_POLL, 3'h3, 1'b0);
    rport(3'h5, 1'b0);
    cmd(dps_pkg::DPS_CMD_ACQUIRE, 3'h5, 1'b0);
    rport(3'h5, 1'b1);
    cmd(dps_pkg::DPS_CMD_POLL, 3'h5, 1'b1);
    cmd(dps_pkg::DPS_CMD_INIT, 3'h0, 1'b0);
    check("owned", owned_q, 8'h00);
    rport(3'h6, 1'b0);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    while (init_done_q !== 1'b1) @(posedge mclk);
    check("owned", owned_q, 8'h00);
    cmd(dps_pkg::DPS_CMD_POLL, 3'h5, 1'b0);
    cmd(dps_pkg::DPS_CMD_ACQUIRE, 3'h6, 1'b0);
    rport(3'h6, 1'b1);
    cmd(dps_pkg::DPS_CMD_POLL, 3'h6, 1'b1);
    repeat (3) @(posedge mclk);
    check("pending", 8'(exp_q.size()), 8'h00);
    end_sim();
  end
endmodule

/* tb/dps_host_chk_sva.sv */
`timescale 1ns/100ps
module dps_host_chk #(
  parameter int ADDR_W = 13,
  parameter int DATA_W = 16
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              cmd_valid,
  input wire dps_pkg::dps_cmd_t cmd_op,
  input wire logic              cmd_ready_q,
  input wire logic              rsp_valid_q,
  input wire logic              rsp_granted_q,
  input wire logic              init_done_q,
  input wire logic              semaphore_select_n_q,
  input wire logic              oe_n_q,
  input wire logic              rw_n_q,
  input wire logic [ADDR_W-1:0] addr_q,
  input wire logic [DATA_W-1:0] io_out_q,
  input wire logic              io_oe_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_TAKE_DROP: assert property (cmd_valid && cmd_ready_q |=> !cmd_ready_q)
    else $error("ready held after take");
  AST_RSP_ONE: assert property (rsp_valid_q |=> !rsp_valid_q)
    else $error("response longer than one cycle");
  AST_ACQ_ANSWER: assert property (
    cmd_valid && cmd_ready_q && cmd_op == dps_pkg::DPS_CMD_ACQUIRE |-> ##[1:40] rsp_valid_q)
    else $error("acquire got no answer");
  AST_READ_OE: assert property (!oe_n_q |-> rw_n_q && !semaphore_select_n_q && !io_oe_q)
    else $error("output enable outside a read");
  AST_WR_DRIVE: assert property (
    io_oe_q |-> !rw_n_q && !semaphore_select_n_q && (io_out_q == '0 || io_out_q == '1))
    else $error("bad write drive");
  AST_ADDR_LOW: assert property (!semaphore_select_n_q |-> addr_q[ADDR_W-1:dps_pkg::IDX_W] == '0)
    else $error("upper address bits set");
  AST_STROBE_LEN: assert property ($fell(semaphore_select_n_q) |-> !semaphore_select_n_q[*8])
    else $error("select strobe too short");
  AST_GAP: assert property ($rose(semaphore_select_n_q) |=> semaphore_select_n_q)
    else $error("select not released between cycles");
  AST_INIT_ONES: assert property (!init_done_q && io_oe_q |-> io_out_q == '1)
    else $error("init wrote a zero");
  AST_NO_CMD_PREINIT: assert property (!init_done_q |-> !cmd_ready_q)
    else $error("command accepted before init");
  cover property (rsp_valid_q && rsp_granted_q);
  cover property (rsp_valid_q && !rsp_granted_q);
  cover property ($rose(init_done_q));
endmodule
bind dps_host dps_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.mclk(mclk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q),
  .rsp_granted_q(rsp_granted_q), .init_done_q(init_done_q), .oe_n_q(oe_n_q), .rw_n_q(rw_n_q),
  .semaphore_select_n_q(semaphore_select_n_q), .addr_q(addr_q), .io_out_q(io_out_q),
  .io_oe_q(io_oe_q));
